// ===== core/adc_mode_control.sv
// Mode pins, serial mode registers, power states and output formatting
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Offset binary by default; signed format bit flips to two's complement.
// R2: Two pad bits sent only in 14-bit and 16-bit serialization modes.
// R3: Pad bits read 00 normally or negative overrange, 11 positive overrange.
// R4: Randomizer XORs every sample bit but the LSB with the LSB.
// R5: Receiver undoes randomizing by XORing received bits with received LSB.
// R6: Test pattern forces sample and pad bits of all channels, overriding formatting.
// R7: Output disable turns off every output pair, clock and frame included.
// R8: Sleep from register bit or power-down pin; ready about 2ms after.
// R9: Nap per channel by serial only; channel needs 100 clock cycles to recover; code counts 100 sample_valid_i cycles instead.
// R10: Host waits a further 50us after nap for accurate DC settling.
// R11: Mode-select high makes port pins static modes; low makes them serial.
// R12: Transfer framed by chip select; only first 16 rising clock edges sampled.
// R13: Host sends read/write flag, seven address bits, eight data bits, MSB first.
// R14: Flag low stores the data bits into the addressed register.
// R15: Flag high shifts addressed register out, leaves it, ignores data bits.
// R16: Serial data output is open drain and only ever pulls low.
// R17: Parallel chip select picks two-lane 16-bit or one-lane 14-bit output.
// R18: Parallel serial clock pin picks 3.5mA or 1.75mA driver current.
// R19: Parallel serial data input pin is power-down: high means sleep.
// R20: Parallel serial data output pin enables internal termination when high.
// R21: Reset bit write clears all mode bits; the bit reads back zero.
// R22: Four low power bits nap channels; top power bit sleeps the device.
// R23: Parallel mode keeps all other features at their reset state.
// R24: Coding first, then randomizing; test pattern replaces the result.
module adc_mode_control #(
  parameter int CHANNELS             = 4,
  parameter int SAMPLE_WIDTH         = 12,
  parameter int SLEEP_RECOVER_CYCLES = adc_mode_pkg::SLEEP_RECOVER_CYCLES
) (
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  input  wire logic                             program_mode_select_i,
  input  wire logic                             cs_n_i,
  input  wire logic                             sck_i,
  input  wire logic                             sdi_i,
  input  wire logic                             sdo_i,
  output logic                                  sdo_o,
  output logic                                  sdo_oe_n_o,
  input  wire logic                             sample_valid_i,
  input  wire logic [CHANNELS*SAMPLE_WIDTH-1:0] raw_samples_i,
  input  wire logic [CHANNELS-1:0]              over_pos_i,
  output logic      [CHANNELS*SAMPLE_WIDTH-1:0] sample_bits_o,
  output logic      [CHANNELS-1:0]              pad_bit_upper_o,
  output logic      [CHANNELS-1:0]              pad_bit_lower_o,
  output logic                                  sample_valid_o,
  output logic      [2:0]                       serial_mode_o,
  output logic      [2:0]                       drive_current_o,
  output logic                                  term_enable_o,
  output logic                                  output_drive_enable_o,
  output logic                                  dcs_off_o,
  output logic                                  sleep_o,
  output logic      [CHANNELS-1:0]              nap_o,
  output logic                                  device_ready_o,
  output logic      [CHANNELS-1:0]              channel_ready_o
);

  localparam int SLEEP_W = $clog2(SLEEP_RECOVER_CYCLES + 1);
  localparam int NAP_W   = $clog2(adc_mode_pkg::NAP_RECOVER_CYCLES + 1);

  if (CHANNELS != 4 || SAMPLE_WIDTH < 2 || SAMPLE_WIDTH > 14 || SLEEP_RECOVER_CYCLES < 1) begin : g_check
    $error("adc_mode_control: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [4:0] pins_meta;
  logic [4:0] pins_sync;
  logic [1:0] sck_hist;
  logic       par_mode;
  logic       cs_n_s;
  logic       sdi_s;
  logic       sdo_s;
  logic       sck_rise;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pins_meta <= 5'h01;
      pins_sync <= 5'h01;
      sck_hist  <= 2'h0;
    end else begin
      pins_meta <= {program_mode_select_i, sck_i, sdi_i, sdo_i, cs_n_i};
      pins_sync <= pins_meta;
      sck_hist  <= {sck_hist[0], pins_sync[3]};
    end
  end

  assign par_mode = pins_sync[4]; // R11
  assign sdi_s    = pins_sync[2];
  assign sdo_s    = pins_sync[1];
  assign cs_n_s   = pins_sync[0];
  assign sck_rise = sck_hist[0] & ~sck_hist[1];

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers

  logic [7:0] fmt_pwr;
  logic [7:0] out_mode;
  logic [7:0] tp_hi;
  logic [7:0] tp_lo;
  logic [7:0] next_fmt_pwr;
  logic [7:0] next_out_mode;
  logic [7:0] next_tp_hi;
  logic [7:0] next_tp_lo;
  logic       wr_go;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  function automatic logic [7:0] reg_read(input logic [6:0] addr, input logic [7:0] fp,
                                          input logic [7:0] om, input logic [7:0] th,
                                          input logic [7:0] tl);
    logic [7:0] val;
    val = 8'h00;
    unique case (addr)
      adc_mode_pkg::ADDR_FMT_PWR:  val = fp;
      adc_mode_pkg::ADDR_OUT_MODE: val = om;
      adc_mode_pkg::ADDR_TP_HI:    val = th;
      adc_mode_pkg::ADDR_TP_LO:    val = tl;
      default:                     val = 8'h00;
    endcase
    return val;
  endfunction : reg_read

  always_comb begin
    next_fmt_pwr  = fmt_pwr;
    next_out_mode = out_mode;
    next_tp_hi    = tp_hi;
    next_tp_lo    = tp_lo;
    if (wr_go) begin
      unique case (wr_addr)
        adc_mode_pkg::ADDR_RESET: begin
          if (wr_data[adc_mode_pkg::RESET_BIT]) begin
            next_fmt_pwr  = adc_mode_pkg::REG_RESET_VAL; // R21
            next_out_mode = adc_mode_pkg::REG_RESET_VAL; // R21
            next_tp_hi    = adc_mode_pkg::REG_RESET_VAL; // R21
            next_tp_lo    = adc_mode_pkg::REG_RESET_VAL; // R21
          end
        end
        adc_mode_pkg::ADDR_FMT_PWR:  next_fmt_pwr  = wr_data; // R14
        adc_mode_pkg::ADDR_OUT_MODE: next_out_mode = wr_data; // R14
        adc_mode_pkg::ADDR_TP_HI:    next_tp_hi    = wr_data; // R14
        adc_mode_pkg::ADDR_TP_LO:    next_tp_lo    = wr_data; // R14
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fmt_pwr  <= adc_mode_pkg::REG_RESET_VAL;
      out_mode <= adc_mode_pkg::REG_RESET_VAL;
      tp_hi    <= adc_mode_pkg::REG_RESET_VAL;
      tp_lo    <= adc_mode_pkg::REG_RESET_VAL;
    end else begin
      fmt_pwr  <= next_fmt_pwr;
      out_mode <= next_out_mode;
      tp_hi    <= next_tp_hi;
      tp_lo    <= next_tp_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port

  adc_mode_pkg::serial_state_type state;
  adc_mode_pkg::serial_state_type next_state;
  logic [4:0]  bit_cnt;
  logic [4:0]  next_bit_cnt;
  logic [14:0] shift_in;
  logic [14:0] next_shift_in;
  logic [7:0]  shift_out;
  logic [7:0]  next_shift_out;
  logic        reading;
  logic        next_reading;

  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_reading   = reading;
    wr_go          = 1'b0;
    wr_addr        = shift_in[13:7];
    wr_data        = {shift_in[6:0], sdi_s};
    if (par_mode || cs_n_s) begin
      next_state   = adc_mode_pkg::ST_IDLE; // R12
      next_reading = 1'b0;
    end else begin
      unique case (state)
        adc_mode_pkg::ST_IDLE: begin
          next_state   = adc_mode_pkg::ST_HEAD; // R12
          next_bit_cnt = 5'h00;
        end
        adc_mode_pkg::ST_HEAD: begin
          if (sck_rise) begin
            next_shift_in = {shift_in[13:0], sdi_s}; // R13
            next_bit_cnt  = bit_cnt + 5'h01;
            if (bit_cnt == 5'(adc_mode_pkg::HEAD_BITS - 1)) begin
              next_state     = adc_mode_pkg::ST_BODY;
              next_reading   = shift_in[6]; // R15
              next_shift_out = reg_read({shift_in[5:0], sdi_s}, fmt_pwr, out_mode, tp_hi, tp_lo); // R15
            end
          end
        end
        adc_mode_pkg::ST_BODY: begin
          if (sck_rise) begin
            next_shift_in  = {shift_in[13:0], sdi_s};
            next_shift_out = {shift_out[6:0], 1'b1};
            next_bit_cnt   = bit_cnt + 5'h01;
            if (bit_cnt == 5'(adc_mode_pkg::WORD_BITS - 1)) begin
              next_state = adc_mode_pkg::ST_DONE;
              wr_go      = ~reading; // R14 R15
            end
          end
        end
        adc_mode_pkg::ST_DONE: begin
          next_state = adc_mode_pkg::ST_DONE; // R12
        end
        default: begin
          next_state = adc_mode_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state     <= adc_mode_pkg::ST_IDLE;
      bit_cnt   <= 5'h00;
      shift_in  <= 15'h0000;
      shift_out <= 8'hFF;
      reading   <= 1'b0;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
      reading   <= next_reading;
    end
  end

  assign sdo_o      = 1'b0; // R16
  assign sdo_oe_n_o = ~(reading && state == adc_mode_pkg::ST_BODY && !shift_out[7]); // R16

  ////////////////////////////////////////////////////////////////////////////
  // Effective modes

  logic                twos_en;
  logic                randomizer_bit_en;
  logic                pattern_en;
  logic                pads_on;
  logic                asleep;
  logic [CHANNELS-1:0] nap_req;
  logic [13:0]         pattern;

  always_comb begin
    twos_en               = fmt_pwr[adc_mode_pkg::SIGNED_BIT]; // R1
    randomizer_bit_en               = fmt_pwr[adc_mode_pkg::RANDOMIZER_BIT_BIT]; // R4
    dcs_off_o             = fmt_pwr[adc_mode_pkg::DCS_OFF_BIT];
    asleep                = fmt_pwr[adc_mode_pkg::SLEEP_BIT]; // R8 R22
    nap_req               = fmt_pwr[adc_mode_pkg::NAP_LSB +: CHANNELS]; // R9 R22
    pattern_en            = tp_hi[adc_mode_pkg::TP_EN_BIT]; // R6
    serial_mode_o         = out_mode[adc_mode_pkg::SER_MODE_LSB +: 3];
    drive_current_o       = out_mode[adc_mode_pkg::CURRENT_LSB +: 3];
    term_enable_o         = out_mode[adc_mode_pkg::TERM_BIT];
    output_drive_enable_o = ~out_mode[adc_mode_pkg::OUT_OFF_BIT]; // R7
    if (par_mode) begin
      twos_en               = 1'b0; // R23
      randomizer_bit_en               = 1'b0; // R23
      dcs_off_o             = 1'b0; // R23
      pattern_en            = 1'b0; // R23
      nap_req               = '0; // R9 R23
      output_drive_enable_o = 1'b1; // R23
      asleep                = sdi_s; // R19
      serial_mode_o         = cs_n_s ? adc_mode_pkg::MODE_1L14 : adc_mode_pkg::MODE_2L16; // R17
      drive_current_o       = pins_sync[3] ? adc_mode_pkg::CUR_1P75MA : adc_mode_pkg::CUR_3P5MA; // R18
      term_enable_o         = sdo_s; // R20
    end
    if (asleep) begin
      output_drive_enable_o = 1'b0; // R8
      nap_req               = '0;
    end
    pattern = {tp_hi[adc_mode_pkg::TP_HI_BITS-1:0], tp_lo};
    pads_on = serial_mode_o inside {adc_mode_pkg::MODE_2L16, adc_mode_pkg::MODE_2L14,
                                    adc_mode_pkg::MODE_1L16, adc_mode_pkg::MODE_1L14}; // R2
  end

  assign sleep_o = asleep; // R8
  assign nap_o   = nap_req; // R9

  ////////////////////////////////////////////////////////////////////////////
  // Recovery timers

  logic [SLEEP_W-1:0] sleep_cnt;
  logic [SLEEP_W-1:0] next_sleep_cnt;
  logic               valid_q;

  always_comb begin
    next_sleep_cnt = sleep_cnt;
    if (asleep) begin
      next_sleep_cnt = SLEEP_W'(SLEEP_RECOVER_CYCLES); // R8
    end else if (sleep_cnt != '0) begin
      next_sleep_cnt = sleep_cnt - 1'b1; // R8
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sleep_cnt <= '0;
      valid_q   <= 1'b0;
    end else begin
      sleep_cnt <= next_sleep_cnt;
      valid_q   <= sample_valid_i;
    end
  end

  assign device_ready_o = !asleep && sleep_cnt == '0;
  assign sample_valid_o = valid_q;

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    logic [NAP_W-1:0] nap_cnt;
    logic [NAP_W-1:0] next_nap_cnt;

    always_comb begin
      next_nap_cnt = nap_cnt;
      if (nap_req[ch] || asleep) begin
        next_nap_cnt = NAP_W'(adc_mode_pkg::NAP_RECOVER_CYCLES); // R9
      end else if (sample_valid_i && nap_cnt != '0) begin
        next_nap_cnt = nap_cnt - 1'b1; // R9
      end
    end

    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        nap_cnt <= '0;
      end else begin
        nap_cnt <= next_nap_cnt;
      end
    end

    assign channel_ready_o[ch] = device_ready_o && !nap_req[ch] && nap_cnt == '0;

    sample_formatter #(
      .WIDTH (SAMPLE_WIDTH)
    ) u_fmt (
      .clk_i           (clk_i),
      .rst_n_i         (rst_n_i),
      .load_i          (sample_valid_i),
      .active_i        (!asleep && !nap_req[ch]),
      .raw_i           (raw_samples_i[ch*SAMPLE_WIDTH +: SAMPLE_WIDTH]),
      .over_pos_i      (over_pos_i[ch]),
      .signed_i        (twos_en),
      .random_i        (randomizer_bit_en),
      .pads_on_i       (pads_on),
      .pattern_en_i    (pattern_en),
      .pattern_i       (pattern[SAMPLE_WIDTH+1:0]),
      .sample_bits_o   (sample_bits_o[ch*SAMPLE_WIDTH +: SAMPLE_WIDTH]),
      .pad_bit_upper_o (pad_bit_upper_o[ch]),
      .pad_bit_lower_o (pad_bit_lower_o[ch])
    );
  end

endmodule : adc_mode_control
`default_nettype wire

// ===== include/adc_mode_pkg.sv
// Constants and types shared by the converter mode and format logic
package adc_mode_pkg;

  // Serial word layout
  localparam int WORD_BITS   = 16;
  localparam int HEAD_BITS   = 8;
  localparam int ADDR_BITS   = 7;
  localparam int DATA_BITS   = 8;

  // Mode register addresses
  localparam logic [6:0] ADDR_RESET    = 7'h00;
  localparam logic [6:0] ADDR_FMT_PWR  = 7'h01;
  localparam logic [6:0] ADDR_OUT_MODE = 7'h02;
  localparam logic [6:0] ADDR_TP_HI    = 7'h03;
  localparam logic [6:0] ADDR_TP_LO    = 7'h04;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // Field positions
  localparam int RESET_BIT     = 7;
  localparam int DCS_OFF_BIT   = 7;
  localparam int RANDOMIZER_BIT_BIT      = 6;
  localparam int SIGNED_BIT    = 5;
  localparam int SLEEP_BIT     = 4;
  localparam int NAP_LSB       = 0;
  localparam int CURRENT_LSB   = 5;
  localparam int TERM_BIT      = 4;
  localparam int OUT_OFF_BIT   = 3;
  localparam int SER_MODE_LSB  = 0;
  localparam int TP_EN_BIT     = 7;
  localparam int TP_HI_BITS    = 6;

  // Serialization mode codes
  localparam logic [2:0] MODE_2L16 = 3'h0;
  localparam logic [2:0] MODE_2L14 = 3'h1;
  localparam logic [2:0] MODE_2L12 = 3'h2;
  localparam logic [2:0] MODE_1L16 = 3'h4;
  localparam logic [2:0] MODE_1L14 = 3'h5;
  localparam logic [2:0] MODE_1L12 = 3'h6;

  // Driver current codes
  localparam logic [2:0] CUR_3P5MA  = 3'h0;
  localparam logic [2:0] CUR_1P75MA = 3'h4;

  // Timing
  localparam int CLK_PERIOD_PS        = 25_000;
  localparam int SLEEP_RECOVER_MS     = 2;
  localparam int SLEEP_RECOVER_CYCLES = (SLEEP_RECOVER_MS * 1_000_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int NAP_RECOVER_CYCLES   = 100;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HEAD = 4'b0010,
    ST_BODY = 4'b0100,
    ST_DONE = 4'b1000
  } serial_state_type;

endpackage : adc_mode_pkg

// ===== core/sample_formatter.sv
// Per-channel output coding, randomizer, pad bits and test pattern
`timescale 1ns/1ps
`default_nettype none
module sample_formatter #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             load_i,
  input  wire logic             active_i,
  input  wire logic [WIDTH-1:0] raw_i,
  input  wire logic             over_pos_i,
  input  wire logic             signed_i,
  input  wire logic             random_i,
  input  wire logic             pads_on_i,
  input  wire logic             pattern_en_i,
  input  wire logic [WIDTH+1:0] pattern_i,
  output logic      [WIDTH-1:0] sample_bits_o,
  output logic                  pad_bit_upper_o,
  output logic                  pad_bit_lower_o
);

  logic [WIDTH-1:0] coded;
  logic [WIDTH-1:0] mixed;
  logic [WIDTH-1:0] next_sample;
  logic [1:0]       next_pads;
  logic [1:0]       pads;

  always_comb begin
    coded = raw_i;
    if (signed_i) begin
      coded[WIDTH-1] = ~raw_i[WIDTH-1]; // R1
    end
    mixed = coded;
    if (random_i) begin
      mixed[WIDTH-1:1] = coded[WIDTH-1:1] ^ {(WIDTH-1){coded[0]}}; // R4 R24
    end
    next_sample = sample_bits_o;
    next_pads   = pads;
    if (!active_i) begin
      next_sample = '0;
      next_pads   = 2'b00;
    end else if (load_i) begin
      next_sample = mixed;
      next_pads   = over_pos_i ? 2'b11 : 2'b00; // R3
      if (pattern_en_i) begin
        next_sample = pattern_i[WIDTH-1:0]; // R6 R24
        next_pads   = pattern_i[WIDTH+1:WIDTH]; // R6
      end
      if (!pads_on_i) begin
        next_pads = 2'b00; // R2
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sample_bits_o <= '0;
      pads          <= 2'b00;
    end else begin
      sample_bits_o <= next_sample;
      pads          <= next_pads;
    end
  end

  assign pad_bit_upper_o = pads[1];
  assign pad_bit_lower_o = pads[0];

endmodule : sample_formatter
`default_nettype wire

// ===== tb/adc_mode_control_assertions.sv
// Port assertions for the mode control block
`timescale 1ns/1ps
`default_nettype none
module adc_mode_control_assertions #(
  parameter int CHANNELS             = 4,
  parameter int SAMPLE_WIDTH         = 12,
  parameter int SLEEP_RECOVER_CYCLES = 20
) (
  input wire logic                             clk_i,
  input wire logic                             rst_n_i,
  input wire logic                             program_mode_select_i,
  input wire logic                             cs_n_i,
  input wire logic                             sck_i,
  input wire logic                             sdi_i,
  input wire logic                             sdo_i,
  input wire logic                             sdo_o,
  input wire logic                             sdo_oe_n_o,
  input wire logic                             sample_valid_i,
  input wire logic [CHANNELS*SAMPLE_WIDTH-1:0] raw_samples_i,
  input wire logic [CHANNELS-1:0]              over_pos_i,
  input wire logic [CHANNELS*SAMPLE_WIDTH-1:0] sample_bits_o,
  input wire logic [CHANNELS-1:0]              pad_bit_upper_o,
  input wire logic [CHANNELS-1:0]              pad_bit_lower_o,
  input wire logic                             sample_valid_o,
  input wire logic [2:0]                       serial_mode_o,
  input wire logic [2:0]                       drive_current_o,
  input wire logic                             term_enable_o,
  input wire logic                             output_drive_enable_o,
  input wire logic                             dcs_off_o,
  input wire logic                             sleep_o,
  input wire logic [CHANNELS-1:0]              nap_o,
  input wire logic                             device_ready_o,
  input wire logic [CHANNELS-1:0]              channel_ready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////////
  sequence par_settled;
    (program_mode_select_i && $stable({cs_n_i, sck_i, sdi_i, sdo_i}))[*4];
  endsequence
  sequence awake_sample;
    sample_valid_i && !sdi_i;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  sdo_low_a: assert property (sdo_o == 1'b0) else $error("sdo drives high");
  par_sdo_off_a: assert property (program_mode_select_i |-> sdo_oe_n_o) else $error("sdo pulled in parallel");
  valid_delay_a: assert property (sample_valid_i |=> sample_valid_o) else $error("valid not delayed");
  pad_short_a: assert property (sample_valid_o && (serial_mode_o inside {3'h2, 3'h6})
    |-> {pad_bit_upper_o, pad_bit_lower_o} == '0) else $error("pads in 12-bit mode");
  par_pins_a: assert property (par_settled |-> serial_mode_o == (cs_n_i ? 3'h5 : 3'h0)
    && drive_current_o == (sck_i ? 3'h4 : 3'h0) && term_enable_o == sdo_i) else $error("pin modes");
  par_power_a: assert property (par_settled |-> sleep_o == sdi_i && nap_o == '0 && !dcs_off_o
    && output_drive_enable_o == !sdi_i) else $error("parallel power");
  par_sample_a: assert property (par_settled ##0 awake_sample |=> sample_bits_o == $past(raw_samples_i)
    && pad_bit_upper_o == $past(over_pos_i) && pad_bit_lower_o == $past(over_pos_i))
    else $error("parallel sample");
  sleep_gate_a: assert property (sleep_o |-> !device_ready_o && nap_o == '0 && channel_ready_o == '0
    && !output_drive_enable_o) else $error("sleep gating");
  nap_ready_a: assert property ((nap_o & channel_ready_o) == '0) else $error("napping ready");
  sleep_wake_a: assert property ($fell(sleep_o) |-> !device_ready_o [*8]) else $error("early wake");
endmodule : adc_mode_control_assertions
`default_nettype wire

// ===== tb/spi_host_model.sv
// Host controller model for the serial mode port
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    sdi_o  = 1'b0;
  end
  // One framed word plus surplus clock edges
  task automatic xfer(input logic [15:0] word, input int extra, output logic [7:0] rd);
    cs_n_o = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--) begin
      sdi_o = word[i];
      #100;
      if (i < 8) rd[i] = sdo_i;
      sck_o = 1'b1;
      #100;
      sck_o = 1'b0;
    end
    for (int i = 0; i < extra; i++) begin
      sdi_o = ~sdi_o;
      #100 sck_o = 1'b1;
      #100 sck_o = 1'b0;
    end
    #100;
    cs_n_o = 1'b1;
    sdi_o  = ~sdi_o;
    #200;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ===== tb/adc_mode_control_tb_top.sv
// Self-checking bench for the mode control block
`timescale 1ns/1ps
`default_nettype none
module adc_mode_control_tb_top;
  localparam int          SLEEP_CYC = 20;
  localparam logic [47:0] RAW       = 48'h123A_BD80_07FF;
  logic        clk_i, rst_n_i, par, sample_valid_i, sdo_o, sdo_oe_n_o, sample_valid_o;
  logic        par_cs_n, par_sck, par_sdi, par_sdo, host_cs_n, host_sck, host_sdi;
  logic        term_enable_o, output_drive_enable_o, dcs_off_o, sleep_o, device_ready_o;
  logic [47:0] raw_samples_i, sample_bits_o;
  logic [3:0]  over_pos_i, pad_bit_upper_o, pad_bit_lower_o, nap_o, channel_ready_o;
  logic [2:0]  serial_mode_o, drive_current_o;
  logic [7:0]  rd;
  int          bad_count, num_checks;
  wire logic   sdo_wire;
  assign sdo_wire = par ? par_sdo : (sdo_oe_n_o ? 1'b1 : sdo_o);
  spi_host_model i_host (.cs_n_o(host_cs_n), .sck_o(host_sck), .sdi_o(host_sdi), .sdo_i(sdo_wire));
  adc_mode_control #(.SLEEP_RECOVER_CYCLES(SLEEP_CYC)) i_dut (
    .clk_i, .rst_n_i, .program_mode_select_i(par), .cs_n_i(par ? par_cs_n : host_cs_n),
    .sck_i(par ? par_sck : host_sck), .sdi_i(par ? par_sdi : host_sdi), .sdo_i(sdo_wire), .sdo_o, .sdo_oe_n_o,
    .sample_valid_i, .raw_samples_i, .over_pos_i, .sample_bits_o, .pad_bit_upper_o, .pad_bit_lower_o,
    .sample_valid_o, .serial_mode_o, .drive_current_o, .term_enable_o, .output_drive_enable_o, .dcs_off_o,
    .sleep_o, .nap_o, .device_ready_o, .channel_ready_o);
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int extra = 0);
    i_host.xfer({1'b0, a, d}, extra, rd);
  endtask : wr
  task automatic rdck(input logic [6:0] a, input logic [7:0] e);
    i_host.xfer({1'b1, a, 8'hFF}, 0, rd);
    check(rd, e);
  endtask : rdck
  task automatic smp(input logic [3:0] ovr);
    sample_valid_i = 1'b1;
    over_pos_i     = ovr;
    tick(1);
    sample_valid_i = 1'b0;
    tick(1);
  endtask : smp
  function automatic logic [47:0] fmt4(input logic [7:0] a1);
    logic [11:0] v;
    for (int c = 0; c < 4; c++) begin
      v = RAW[c*12+:12];
      v[11] = v[11] ^ a1[5];
      if (a1[6]) v[11:1] = v[11:1] ^ {11{v[0]}};
      fmt4[c*12+:12] = v;
    end
  endfunction : fmt4
  function automatic logic [47:0] undo(input logic [47:0] s);
    undo = s;
    for (int c = 0; c < 48; c += 12) undo[c+1+:11] ^= {11{s[c]}};
  endfunction : undo
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #400_000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    logic [2:0] modes [6];
    modes = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    {rst_n_i, par, sample_valid_i, par_cs_n, par_sck, par_sdi, par_sdo} = '0;
    raw_samples_i = RAW;
    over_pos_i    = 4'h0;
    tick(4);
    rst_n_i = 1'b1;
    tick(3);
    wr(adc_mode_pkg::ADDR_RESET, 8'h80);
    rdck(adc_mode_pkg::ADDR_RESET, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(adc_mode_pkg::ADDR_FMT_PWR, 8'(k << 5));
      smp(4'h0);
      check(sample_bits_o, fmt4(8'(k << 5)));
      if (k > 1) check(undo(sample_bits_o), fmt4(8'(k << 5) & 8'h20));
    end
    foreach (modes[k]) begin
      wr(adc_mode_pkg::ADDR_OUT_MODE, {5'h00, modes[k]});
      smp(4'h6);
      check(serial_mode_o, modes[k]);
      check(pad_bit_upper_o, modes[k][1] ? 4'h0 : 4'h6);
      check(pad_bit_lower_o, modes[k][1] ? 4'h0 : 4'h6);
    end
    wr(adc_mode_pkg::ADDR_OUT_MODE, 8'h00);
    wr(adc_mode_pkg::ADDR_TP_LO, 8'h5A, 4);
    rdck(adc_mode_pkg::ADDR_TP_LO, 8'h5A);
    wr(adc_mode_pkg::ADDR_TP_HI, 8'hA6);
    smp(4'h0);
    check(sample_bits_o, {4{12'h65A}});
    check({pad_bit_upper_o, pad_bit_lower_o}, 8'hF0);
    rdck(adc_mode_pkg::ADDR_TP_HI, 8'hA6);
    wr(7'h55, 8'hFF);
    rdck(7'h55, 8'h00);
    wr(adc_mode_pkg::ADDR_TP_HI, 8'h00);
    wr(adc_mode_pkg::ADDR_OUT_MODE, 8'h08);
    check(output_drive_enable_o, 1'b0);
    wr(adc_mode_pkg::ADDR_OUT_MODE, 8'h00);
    check(output_drive_enable_o, 1'b1);
    wr(adc_mode_pkg::ADDR_FMT_PWR, 8'h05);
    smp(4'h0);
    check(nap_o, 4'h5);
    check(sample_bits_o, {RAW[47:36], 12'h000, RAW[23:12], 12'h000});
    wr(adc_mode_pkg::ADDR_FMT_PWR, 8'h00);
    repeat (99) smp(4'h0);
    check(channel_ready_o, 4'hA);
    smp(4'h0);
    check(channel_ready_o, 4'hF);
    tick(2000);
    wr(adc_mode_pkg::ADDR_FMT_PWR, 8'h10);
    check({sleep_o, device_ready_o}, 2'b10);
    wr(adc_mode_pkg::ADDR_FMT_PWR, 8'h00);
    check(device_ready_o, 1'b0);
    tick(SLEEP_CYC);
    check(device_ready_o, 1'b1);
    wr(adc_mode_pkg::ADDR_FMT_PWR, 8'h60);
    wr(adc_mode_pkg::ADDR_RESET, 8'h80);
    rdck(adc_mode_pkg::ADDR_FMT_PWR, 8'h00);
    par = 1'b1;
    for (int p = 0; p < 16; p++) begin
      {par_cs_n, par_sck, par_sdi, par_sdo} = 4'(p);
      tick(5);
      check(serial_mode_o, par_cs_n ? 3'h5 : 3'h0);
      check(sleep_o, par_sdi);
      smp(4'h9);
    end
    report_and_stop();
  end
endmodule : adc_mode_control_tb_top
bind adc_mode_control adc_mode_control_assertions #(
  .CHANNELS(CHANNELS), .SAMPLE_WIDTH(SAMPLE_WIDTH), .SLEEP_RECOVER_CYCLES(SLEEP_RECOVER_CYCLES)) i_chk (
  .clk_i, .rst_n_i, .program_mode_select_i, .cs_n_i, .sck_i, .sdi_i, .sdo_i, .sdo_o, .sdo_oe_n_o,
  .sample_valid_i, .raw_samples_i, .over_pos_i, .sample_bits_o, .pad_bit_upper_o, .pad_bit_lower_o,
  .sample_valid_o, .serial_mode_o, .drive_current_o, .term_enable_o, .output_drive_enable_o, .dcs_off_o,
  .sleep_o, .nap_o, .device_ready_o, .channel_ready_o);
`default_nettype wire
